// ---- rtl/cmc_top.sv ----
// can operating-mode controller with apb register slave
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Overview of operation
// - modes requested via control bits 7:5
// - error recognition selected by rx buffer mode
// - mode in force shown in status field
// - mode change waits for pending transmissions, except the return from sleep on a wake edge
// - top request bit asks for configuration
// - writing zero request goes to normal, or to error recognition if rx buffer mode is 3
// - config registers locked outside configuration
// - configuration entry waits for frame end, except the return from sleep to configuration on a wake edge
// - configuration: no traffic, counters cleared
// - configuration releases pins to general io
// - request 001 selects disable/sleep
// - sleep stops module clock when inactive
// - busy sleep request waits 11 recessive bits
// - status reads 001 only once asleep
// - wake flag set by bus edge, gated irq
// - wake returns to prior mode, frame dropped
// - tx pin recessive throughout sleep
// - only normal mode transmits; acks, errors
// - six buffers of eight bytes, modes 1-3
// - data bytes writable only in transmit direction
// ----------------------------------------------------------------------
module cmc_top
	import cmc_pkg::*;
#(
	parameter int NUM_BUF   = 6,
	parameter int BUF_BYTES = 8
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bus_rx,
	input  wire logic        bit_tick,
	input  wire logic        frame_active,
	input  wire logic        tx_pending,
	input  wire logic        core_tx_bit,
	output logic             can_tx_pin,
	output logic             tx_enable,
	output logic             rx_enable,
	output logic             ack_err_enable,
	output logic             pins_as_gpio,
	output logic             err_cnt_clear,
	output logic             module_clk_en,
	output logic             wake_irq,
	output logic             wake_discard,
	output logic             triple_sample_select,
	output logic             phase2_free_select,
	output logic      [3:0]  phase1_tq,
	output logic      [3:0]  prop_tq,
	output logic      [31:0] filter_val,
	output logic      [31:0] mask_val,
	output logic      [7:0]  filter_mask_ctl
);
	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	cmc_state_e  state_r;
	cmc_state_e  prev_r;
	logic [2:0]  requested_op_field_r;
	logic        wake_flag_r;
	logic        wake_irq_enable_r;
	logic        wake_disable_r;
	logic [1:0]  func_mode_r;
	logic [1:0]  rx_buffer_mode_field_r;
	logic [NUM_BUF-1:0] buffer_direction_reg_r;
	logic [7:0]  bit_timing_control_two_r;
	logic [31:0] filter_r;
	logic [31:0] mask_r;
	logic [7:0]  fmctl_r;
	logic [3:0]  idle_cnt_r;
	logic        rx_prev_r;
	logic        discard_r;
	logic [7:0]  buffer_data_byte_r [NUM_BUF*BUF_BYTES];

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	logic        wr_en;
	logic        rd_en;
	logic        locked;
	logic        enhanced;
	logic        in_data;
	logic [2:0]  buf_idx;
	logic [2:0]  byte_idx;
	logic [5:0]  data_idx;
	logic        data_ok;
	logic [2:0]  op_status;
	logic        bus_idle;
	logic        wake_edge;
	cmc_state_e  target;
	logic        may_change;

	assign wr_en    = psel & penable & pwrite;
	assign rd_en    = psel & penable & ~pwrite;
	assign pready   = 1'b1;
	assign locked   = (state_r != CMC_ST_CONFIG);
	assign enhanced = (func_mode_r != CMC_FN_LEGACY);
	assign in_data  = (paddr >= CMC_DATA_BASE) && (paddr < CMC_DATA_END);
	assign buf_idx  = paddr[7:5];
	assign byte_idx = paddr[4:2];
	assign data_idx = 6'(buf_idx * BUF_BYTES + byte_idx);
	assign data_ok  = in_data && (32'(buf_idx) < NUM_BUF) && (paddr[1:0] == 2'h0);
	assign bus_idle = (idle_cnt_r == CMC_IDLE_BITS);
	assign wake_edge = (state_r == CMC_ST_SLEEP) && rx_prev_r && !bus_rx;

	// ------------------------------------------------------------------
	// mode selection
	// ------------------------------------------------------------------
	always_comb
	begin
		unique case (requested_op_field_r)
			CMC_OP_NORMAL:
				target = (rx_buffer_mode_field_r == CMC_RXMODE_ERRREC)
					? CMC_ST_ERRREC : CMC_ST_NORMAL;
			CMC_OP_SLEEP:    target = CMC_ST_SLEEP;
			CMC_OP_LOOPBACK: target = CMC_ST_LOOPBACK;
			CMC_OP_LISTEN:   target = CMC_ST_LISTEN;
			default:         target = CMC_ST_CONFIG;
		endcase
	end

	always_comb
	begin
		may_change = !tx_pending;
		if (target == CMC_ST_CONFIG)
			may_change = may_change && !frame_active;
		else if (target == CMC_ST_SLEEP)
			may_change = may_change && (!frame_active || bus_idle);
	end

	// error recognition reports as a listen-style code of its own
	always_comb
	begin
		unique case (state_r)
			CMC_ST_CONFIG:   op_status = CMC_OP_CONFIG;
			CMC_ST_SLEEP:    op_status = CMC_OP_SLEEP;
			CMC_ST_NORMAL:   op_status = CMC_OP_NORMAL;
			CMC_ST_LISTEN:   op_status = CMC_OP_LISTEN;
			CMC_ST_LOOPBACK: op_status = CMC_OP_LOOPBACK;
			CMC_ST_ERRREC:   op_status = CMC_OP_ERRREC;
			default:         op_status = CMC_OP_CONFIG;
		endcase
	end

	// ------------------------------------------------------------------
	// mode state
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= CMC_ST_CONFIG;
			prev_r  <= CMC_ST_CONFIG;
		end
		else if (wake_edge)
			state_r <= prev_r;
		else if (target != state_r && may_change)
		begin
			state_r <= target;
			if (target == CMC_ST_SLEEP)
				prev_r <= state_r;
		end
	end

	// ------------------------------------------------------------------
	// bus idle and wake detection
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idle_cnt_r <= 4'h0;
		// a dominant level at any clock breaks the recessive run, so a
		// frame that starts between bit ticks is never taken as idle
		else if (bus_rx != CMC_RECESSIVE)
			idle_cnt_r <= 4'h0;
		else if (bit_tick && !bus_idle)
			idle_cnt_r <= idle_cnt_r + 4'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_prev_r <= CMC_RECESSIVE;
		else
			rx_prev_r <= bus_rx;
	end

	// the waking frame is dropped silently; firmware must retry it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			discard_r <= 1'b0;
		else if (wake_edge)
			discard_r <= 1'b1;
		else if (!frame_active)
			discard_r <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_flag_r <= 1'b0;
		else if (wake_edge)
			wake_flag_r <= 1'b1;
		else if (wr_en && paddr == CMC_WAKE_OFF && pwdata[CMC_WAKE_FLAG])
			wake_flag_r <= 1'b0;
	end

	// ------------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------------
	// hardware rewrites the request on wake so sleep is not re-entered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			requested_op_field_r <= CMC_OP_CONFIG;
		else if (wake_edge)
			requested_op_field_r <= (prev_r == CMC_ST_CONFIG) ? CMC_OP_CONFIG :
				(prev_r == CMC_ST_LISTEN)   ? CMC_OP_LISTEN :
				(prev_r == CMC_ST_LOOPBACK) ? CMC_OP_LOOPBACK : CMC_OP_NORMAL;
		else if (wr_en && paddr == CMC_CTRL_OFF)
			requested_op_field_r <= pwdata[CMC_OP_HI:CMC_OP_LO];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wake_irq_enable_r <= 1'b0;
			wake_disable_r    <= 1'b0;
			buffer_direction_reg_r <= '0;
		end
		else if (wr_en && paddr == CMC_WAKE_OFF)
		begin
			wake_irq_enable_r <= pwdata[CMC_WAKE_IE];
			wake_disable_r    <= pwdata[CMC_WAKE_DIS];
		end
		else if (wr_en && paddr == CMC_BUFDIR_OFF)
			buffer_direction_reg_r <= pwdata[NUM_BUF-1:0];
	end

	// locked group: writes dropped unless configuration is in force
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			func_mode_r              <= CMC_FN_LEGACY;
			rx_buffer_mode_field_r   <= 2'h0;
			bit_timing_control_two_r <= CMC_BITTIM_RST;
			filter_r                 <= 32'h0;
			mask_r                   <= 32'h0;
			fmctl_r                  <= 8'h0;
		end
		else if (wr_en && !locked)
		begin
			if (paddr == CMC_MODESEL_OFF)
			begin
				func_mode_r            <= pwdata[CMC_FN_HI:CMC_FN_LO];
				rx_buffer_mode_field_r <= pwdata[CMC_RXMODE_HI:CMC_RXMODE_LO];
			end
			if (paddr == CMC_BITTIM_OFF)
				bit_timing_control_two_r <= pwdata[7:0];
			if (paddr == CMC_FILTER_OFF)
				filter_r <= pwdata;
			if (paddr == CMC_MASK_OFF)
				mask_r <= pwdata;
			if (paddr == CMC_FMCTL_OFF)
				fmctl_r <= pwdata[7:0];
		end
	end

	// data bytes have no reset: power-on contents are undefined
	always_ff @(posedge pclk)
	begin
		if (wr_en && data_ok && enhanced && buffer_direction_reg_r[buf_idx])
			buffer_data_byte_r[data_idx] <= pwdata[7:0];
	end

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	always_comb
	begin
		prdata  = 32'h0;
		pslverr = 1'b0;
		if (data_ok)
		begin
			if (enhanced)
				prdata[7:0] = buffer_data_byte_r[data_idx];
		end
		else
		begin
			unique case (paddr)
				CMC_CTRL_OFF:
					prdata[CMC_OP_HI:CMC_OP_LO] = requested_op_field_r;
				CMC_STAT_OFF:
					prdata[CMC_OP_HI:CMC_OP_LO] = op_status;
				CMC_WAKE_OFF:
				begin
					prdata[CMC_WAKE_FLAG] = wake_flag_r;
					prdata[CMC_WAKE_IE]   = wake_irq_enable_r;
					prdata[CMC_WAKE_DIS]  = wake_disable_r;
				end
				CMC_MODESEL_OFF:
				begin
					prdata[CMC_FN_HI:CMC_FN_LO]   = func_mode_r;
					prdata[CMC_RXMODE_HI:CMC_RXMODE_LO] = rx_buffer_mode_field_r;
				end
				CMC_BUFDIR_OFF: prdata[NUM_BUF-1:0] = buffer_direction_reg_r;
				CMC_BITTIM_OFF: prdata[7:0] = bit_timing_control_two_r;
				CMC_FILTER_OFF: prdata = filter_r;
				CMC_MASK_OFF:   prdata = mask_r;
				CMC_FMCTL_OFF:  prdata[7:0] = fmctl_r;
				default:        pslverr = psel & penable;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// link-side controls
	// ------------------------------------------------------------------
	assign tx_enable      = (state_r == CMC_ST_NORMAL);
	assign rx_enable      = (state_r != CMC_ST_CONFIG)
		&& (state_r != CMC_ST_SLEEP);
	assign ack_err_enable = (state_r == CMC_ST_NORMAL);
	assign pins_as_gpio   = (state_r == CMC_ST_CONFIG);
	assign err_cnt_clear  = (state_r == CMC_ST_CONFIG);
	// clock kept running while a frame finishes after sleep entry
	assign module_clk_en  = (state_r != CMC_ST_SLEEP) || frame_active;
	assign can_tx_pin     = tx_enable ? core_tx_bit : CMC_RECESSIVE;
	assign wake_irq       = wake_flag_r && wake_irq_enable_r
		&& !wake_disable_r;
	assign wake_discard   = discard_r;
	assign triple_sample_select = bit_timing_control_two_r[CMC_TRIPLE];
	assign phase2_free_select   = bit_timing_control_two_r[CMC_PH2_FREE];
	assign phase1_tq = {1'b0, bit_timing_control_two_r[CMC_PH1_HI:CMC_PH1_LO]}
		+ 4'h1;
	assign prop_tq   = {1'b0, bit_timing_control_two_r[CMC_PROP_HI:CMC_PROP_LO]}
		+ 4'h1;
	assign filter_val      = filter_r;
	assign mask_val        = mask_r;
	assign filter_mask_ctl = fmctl_r;
endmodule // cmc_top
`default_nettype wire

// ---- rtl/cmc_pkg.sv ----
// package of constants for the can mode controller
package cmc_pkg;
	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [11:0] CMC_CTRL_OFF    = 12'h000;
	localparam logic [11:0] CMC_STAT_OFF    = 12'h004;
	localparam logic [11:0] CMC_WAKE_OFF    = 12'h008;
	localparam logic [11:0] CMC_MODESEL_OFF = 12'h00c;
	localparam logic [11:0] CMC_BUFDIR_OFF  = 12'h010;
	localparam logic [11:0] CMC_BITTIM_OFF  = 12'h014;
	localparam logic [11:0] CMC_FILTER_OFF  = 12'h018;
	localparam logic [11:0] CMC_MASK_OFF    = 12'h01c;
	localparam logic [11:0] CMC_FMCTL_OFF   = 12'h020;
	localparam logic [11:0] CMC_DATA_BASE   = 12'h100;
	localparam logic [11:0] CMC_DATA_END    = 12'h1c0;

	// ------------------------------------------------------------------
	// field positions and widths
	// ------------------------------------------------------------------
	localparam int CMC_OP_HI      = 7;
	localparam int CMC_OP_LO      = 5;
	localparam int CMC_WAKE_FLAG  = 0;
	localparam int CMC_WAKE_IE    = 1;
	localparam int CMC_WAKE_DIS   = 2;
	localparam int CMC_FN_HI      = 1;
	localparam int CMC_FN_LO      = 0;
	localparam int CMC_RXMODE_HI  = 3;
	localparam int CMC_RXMODE_LO  = 2;
	localparam int CMC_PH2_FREE   = 7;
	localparam int CMC_TRIPLE     = 6;
	localparam int CMC_PH1_HI     = 5;
	localparam int CMC_PH1_LO     = 3;
	localparam int CMC_PROP_HI    = 2;
	localparam int CMC_PROP_LO    = 0;

	// ------------------------------------------------------------------
	// operation codes, shared by request and status fields except errrec (status only); other constants
	// ------------------------------------------------------------------
	localparam logic [2:0] CMC_OP_NORMAL   = 3'h0;
	localparam logic [2:0] CMC_OP_SLEEP    = 3'h1;
	localparam logic [2:0] CMC_OP_LOOPBACK = 3'h2;
	localparam logic [2:0] CMC_OP_LISTEN   = 3'h3;
	localparam logic [2:0] CMC_OP_CONFIG   = 3'h4;
	localparam logic [2:0] CMC_OP_ERRREC   = 3'h7;
	localparam logic [1:0] CMC_RXMODE_ERRREC = 2'h3;
	localparam logic [1:0] CMC_FN_LEGACY   = 2'h0;
	localparam logic [7:0] CMC_BITTIM_RST  = 8'h00;
	localparam logic [3:0] CMC_IDLE_BITS   = 4'hb;
	localparam logic       CMC_RECESSIVE   = 1'b1;

	typedef enum logic [2:0] {
		CMC_ST_CONFIG,
		CMC_ST_SLEEP,
		CMC_ST_NORMAL,
		CMC_ST_LISTEN,
		CMC_ST_LOOPBACK,
		CMC_ST_ERRREC
	} cmc_state_e;
endpackage

// ---- bench/cmc_properties.sv ----
// port-level checker of the can mode controller
`timescale 1ns/10ps
`default_nettype none
module cmc_properties
	import cmc_pkg::*;
#(
	parameter int NUM_BUF   = 6,
	parameter int BUF_BYTES = 8
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        frame_active,
	input wire logic        tx_pending,
	input wire logic        core_tx_bit,
	input wire logic        can_tx_pin,
	input wire logic        tx_enable,
	input wire logic        rx_enable,
	input wire logic        ack_err_enable,
	input wire logic        pins_as_gpio,
	input wire logic        err_cnt_clear,
	input wire logic        module_clk_en,
	input wire logic        wake_irq,
	input wire logic        triple_sample_select,
	input wire logic [3:0]  phase1_tq,
	input wire logic [3:0]  prop_tq
);
	logic [31:0] wd_r;
	wire logic   bt_wr = psel && penable && pwrite && paddr == CMC_BITTIM_OFF;
	always_ff @(posedge pclk)
		wd_r <= pwdata;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_tx_recessive_idle: assert property (!tx_enable |-> can_tx_pin)
		else $error("tx pin dominant outside normal");
	a_tx_follows_core: assert property (
		tx_enable |-> can_tx_pin == core_tx_bit)
		else $error("tx pin ignores core bit");
	a_ack_only_normal: assert property (ack_err_enable == tx_enable)
		else $error("ack enable outside normal");
	a_config_silent: assert property (
		pins_as_gpio |-> !tx_enable && !rx_enable && err_cnt_clear)
		else $error("traffic in configuration");
	a_clock_gate: assert property (
		!module_clk_en |-> !frame_active && !rx_enable && !pins_as_gpio)
		else $error("clock stopped while active");
	a_hold_pending: assert property (
		tx_pending |=> $stable(tx_enable) && $stable(rx_enable)
		&& $stable(pins_as_gpio))
		else $error("mode changed with tx pending");
	a_cfg_waits_bus: assert property (
		$rose(pins_as_gpio) |-> !$past(frame_active) && !$past(tx_pending))
		else $error("configuration entered during frame");
	a_lock_timing: assert property (
		bt_wr && !pins_as_gpio |=> $stable(phase1_tq) && $stable(prop_tq)
		&& $stable(triple_sample_select))
		else $error("bit timing written while online");
	a_phase_length: assert property (
		bt_wr && pins_as_gpio |=> phase1_tq == {1'h0, wd_r[5:3]} + 4'h1
		&& prop_tq == {1'h0, wd_r[2:0]} + 4'h1)
		else $error("segment length not field plus one");
	a_sample_mode: assert property (
		bt_wr && pins_as_gpio |=> triple_sample_select == wd_r[6])
		else $error("sample mode bit lost");
	c_sleep: cover property (!module_clk_en);
	c_wake: cover property (wake_irq);
	c_locked: cover property (bt_wr && !pins_as_gpio);
endmodule // cmc_properties
bind cmc_top cmc_properties #(.NUM_BUF(NUM_BUF), .BUF_BYTES(BUF_BYTES)) u_p (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.frame_active(frame_active), .tx_pending(tx_pending),
	.core_tx_bit(core_tx_bit), .can_tx_pin(can_tx_pin),
	.tx_enable(tx_enable), .rx_enable(rx_enable),
	.ack_err_enable(ack_err_enable), .pins_as_gpio(pins_as_gpio),
	.err_cnt_clear(err_cnt_clear), .module_clk_en(module_clk_en),
	.wake_irq(wake_irq), .triple_sample_select(triple_sample_select),
	.phase1_tq(phase1_tq), .prop_tq(prop_tq));
`default_nettype wire

// ---- bench/cmc_bus_node.sv ----
// behavioural model of the other nodes on the can bus
`timescale 1ns/10ps
`default_nettype none
module cmc_bus_node (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic go,
	output logic      bus_rx,
	output logic      bit_tick,
	output logic      frame_active
);
	logic [1:0] div_r;
	logic [4:0] bit_r;
	// four clocks a bit keeps the idle count short
	assign bit_tick = div_r == 2'h3;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			div_r <= 2'h0;
		else
			div_r <= div_r + 2'h1;
	// dominant, recessive, dominant bit, then a long recessive tail; idle pulled recessive
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			frame_active <= 1'h0;
			bit_r        <= 5'h0;
			bus_rx       <= 1'h1;
		end
		else if (go && !frame_active)
		begin
			frame_active <= 1'h1;
			bit_r        <= 5'h0;
			bus_rx       <= 1'h0;
		end
		else if (frame_active && bit_tick)
		begin
			bit_r        <= bit_r + 5'h1;
			bus_rx       <= bit_r != 5'h1;
			frame_active <= bit_r != 5'h13;
		end
endmodule // cmc_bus_node
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench of the can mode controller
`timescale 1ns/10ps
`default_nettype none
module testbench
	import cmc_pkg::*;
;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel, penable, pwrite, bt_go, tx_pending, core_tx_bit, slv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, bus_rx, bit_tick, frame_active, can_tx_pin;
	logic        tx_enable, rx_enable, ack_err_enable, pins_as_gpio;
	logic        err_cnt_clear, module_clk_en, wake_irq, wake_discard, tss;
	logic [3:0]  phase1_tq, prop_tq;
	logic        p2f;
	logic [31:0] fval, mval;
	logic [7:0]  fmc;
	int          fails, n_compared;
	localparam logic [11:0] LAST_BYTE = CMC_DATA_BASE + 12'hbc;
	always #50 pclk = ~pclk;
	cmc_top dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_rx(bus_rx),
		.bit_tick(bit_tick), .frame_active(frame_active),
		.tx_pending(tx_pending), .core_tx_bit(core_tx_bit),
		.can_tx_pin(can_tx_pin), .tx_enable(tx_enable), .rx_enable(rx_enable),
		.ack_err_enable(ack_err_enable), .pins_as_gpio(pins_as_gpio),
		.err_cnt_clear(err_cnt_clear), .module_clk_en(module_clk_en),
		.wake_irq(wake_irq), .wake_discard(wake_discard),
		.triple_sample_select(tss), .phase2_free_select(p2f),
		.phase1_tq(phase1_tq), .prop_tq(prop_tq), .filter_val(fval),
		.mask_val(mval), .filter_mask_ctl(fmc));
	cmc_bus_node u_node (.pclk(pclk), .presetn(presetn), .go(bt_go),
		.bus_rx(bus_rx), .bit_tick(bit_tick), .frame_active(frame_active));
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'h1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		rd  = prdata;
		slv = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1)
		begin
			chk(pready, 32'h1);
			stop_test;
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	// status polled by software before it goes on
	task poll(input logic [2:0] m);
		int i;
		apb(1'h0, CMC_STAT_OFF, 32'h0);
		for (i = 0; i < 60 && rd[7:5] !== m; i++)
			apb(1'h0, CMC_STAT_OFF, 32'h0);
		chk(rd[7:5], m);
		if (rd[7:5] !== m)
			stop_test;
	endtask
	task frame;
		@(posedge pclk);
		bt_go <= 1'h1;
		@(posedge pclk);
		bt_go <= 1'h0;
	endtask
	task wait_idle;
		for (int i = 0; i < 200; i++)
		begin
			@(negedge pclk);
			if (!frame_active)
				return;
		end
		chk(frame_active, 32'h0);
		stop_test;
	endtask
	task t_reset;
		chk(pins_as_gpio, 32'h1);
		rdc(CMC_STAT_OFF, 32'h80);
		rdc(CMC_BITTIM_OFF, 32'h0);
		apb(1'h0, 12'h024, 32'h0);
		chk({slv, rd[30:0]}, 32'h80000000);
	endtask
	task t_config;
		wr(CMC_BITTIM_OFF, 32'hff);
		@(negedge pclk);
		chk({p2f, tss, phase1_tq, prop_tq}, 32'h388);
		wr(CMC_BITTIM_OFF, 32'h12);
		@(negedge pclk);
		chk({p2f, tss, phase1_tq, prop_tq}, 32'h033);
		wr(CMC_FILTER_OFF, 32'h1234abcd);
		wr(CMC_MASK_OFF, 32'h0f0f0f0f);
		wr(CMC_FMCTL_OFF, 32'h5a);
		@(negedge pclk);
		chk(fval, 32'h1234abcd);
		chk(mval, 32'h0f0f0f0f);
		chk({24'h0, fmc}, 32'h5a);
		rdc(CMC_DATA_BASE, 32'h0);
		wr(CMC_MODESEL_OFF, 32'h1);
		wr(CMC_BUFDIR_OFF, 32'h20);
		wr(LAST_BYTE, 32'h3c);
		rdc(LAST_BYTE, 32'h3c);
		wr(CMC_BUFDIR_OFF, 32'h0);
		wr(LAST_BYTE, 32'hc3);
		rdc(LAST_BYTE, 32'h3c);
		wr(CMC_MODESEL_OFF, 32'h0);
	endtask
	task t_modes;
		logic [2:0] ml [2] = '{CMC_OP_LISTEN, CMC_OP_LOOPBACK};
		@(posedge pclk);
		tx_pending <= 1'h1;
		wr(CMC_CTRL_OFF, 32'h0);
		repeat (2) rdc(CMC_STAT_OFF, 32'h80);
		tx_pending <= 1'h0;
		core_tx_bit <= 1'h0;
		poll(CMC_OP_NORMAL);
		@(negedge pclk);
		chk({tx_enable, ack_err_enable, can_tx_pin}, 32'h6);
		wr(CMC_BITTIM_OFF, 32'hff);
		rdc(CMC_BITTIM_OFF, 32'h12);
		wr(CMC_FILTER_OFF, 32'h0);
		wr(CMC_MASK_OFF, 32'h0);
		wr(CMC_FMCTL_OFF, 32'h0);
		wr(CMC_MODESEL_OFF, 32'h3);
		@(negedge pclk);
		chk(fval, 32'h1234abcd);
		chk(mval, 32'h0f0f0f0f);
		chk({24'h0, fmc}, 32'h5a);
		rdc(CMC_MODESEL_OFF, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			wr(CMC_CTRL_OFF, {24'h0, ml[k], 5'h0});
			poll(ml[k]);
			@(negedge pclk);
			chk({rx_enable, tx_enable, can_tx_pin}, 32'h5);
		end
		wr(CMC_CTRL_OFF, 32'h0);
		poll(CMC_OP_NORMAL);
	endtask
	task t_sleep;
		wr(CMC_WAKE_OFF, 32'h2);
		frame;
		wr(CMC_CTRL_OFF, 32'h20);
		rdc(CMC_STAT_OFF, 32'h0);
		poll(CMC_OP_SLEEP);
		@(negedge pclk);
		chk({frame_active, module_clk_en}, 32'h3);
		wait_idle;
		chk({module_clk_en, can_tx_pin}, 32'h1);
		frame;
		poll(CMC_OP_NORMAL);
		@(negedge pclk);
		chk({wake_irq, wake_discard}, 32'h3);
		rdc(CMC_CTRL_OFF, 32'h0);
		wait_idle;
		@(negedge pclk);
		chk(wake_discard, 32'h0);
		wr(CMC_WAKE_OFF, 32'h6);
		@(negedge pclk);
		chk(wake_irq, 32'h0);
		rdc(CMC_WAKE_OFF, 32'h7);
		wr(CMC_WAKE_OFF, 32'h3);
		rdc(CMC_WAKE_OFF, 32'h2);
		@(negedge pclk);
		chk(wake_irq, 32'h0);
	endtask
	task t_cfg_busy;
		frame;
		wr(CMC_CTRL_OFF, 32'h80);
		rdc(CMC_STAT_OFF, 32'h0);
		wait_idle;
		poll(CMC_OP_CONFIG);
		@(negedge pclk);
		chk({pins_as_gpio, err_cnt_clear, rx_enable}, 32'h6);
		wr(CMC_MODESEL_OFF, 32'hc);
		wr(CMC_CTRL_OFF, 32'h0);
		poll(CMC_OP_ERRREC);
		@(negedge pclk);
		chk({rx_enable, tx_enable}, 32'h2);
	endtask
	initial
	begin
		{psel, penable, pwrite, bt_go, tx_pending} = 5'h0;
		core_tx_bit = 1'h1;
		paddr = 12'h0;
		pwdata = 32'h0;
		rd = 32'h0;
		fails = 0;
		n_compared = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		t_reset;
		t_config;
		t_modes;
		t_sleep;
		t_cfg_busy;
		stop_test;
	end
endmodule // testbench
`default_nettype wire
